// ===== rtcc_defs.vh
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH

// register offsets, shared between the clock page and the alarm page
`define RTCC_ADDR_W         16
`define RTCC_OFS_SEC        16'h0320
`define RTCC_OFS_MIN        16'h0321
`define RTCC_OFS_HOUR       16'h0322
`define RTCC_OFS_WDAY       16'h0323
`define RTCC_OFS_DATE       16'h0324
`define RTCC_OFS_MONTH      16'h0325
`define RTCC_OFS_YEAR       16'h0326
`define RTCC_OFS_PAGE_CTRL  16'h0327
`define RTCC_OFS_RESET_CTRL 16'h1328

// page control field positions
`define RTCC_PC_IRQ_EN      7
`define RTCC_PC_ADJUST      4
`define RTCC_PC_COUNT_EN    3
`define RTCC_PC_ALARM_EN    2
`define RTCC_PC_PAGE        0

// reset control field positions; bits 3..0 must be written as zero
`define RTCC_RC_SLOW_DIS    7
`define RTCC_RC_FAST_DIS    6
`define RTCC_RC_DIV_RST     5
`define RTCC_RC_ALM_RST     4

// writable bits of each bcd field except the year, which is written whole
`define RTCC_MASK_SEC       8'h7f
`define RTCC_MASK_MIN       8'h7f
`define RTCC_MASK_HOUR      8'h3f
`define RTCC_MASK_WDAY      8'h07
`define RTCC_MASK_DATE      8'h3f
`define RTCC_MASK_MONTH     8'h1f

// reset values of the control bits
`define RTCC_RST_IRQ_EN     1'b0
`define RTCC_RST_COUNT_EN   1'b0
`define RTCC_RST_ALARM_EN   1'b0
`define RTCC_RST_PAGE       1'b0
`define RTCC_RST_SLOW_DIS   1'b1
`define RTCC_RST_FAST_DIS   1'b1

// divider: 15 stages from 32.768 khz give 1 hz; 16 hz sits four stages earlier
`define RTCC_DIV_STAGES     15
`define RTCC_FAST_TAP_BACK  4

`endif

// ===== rtcc_sync2.v
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; only the second stage leaves this module
module rtcc_sync2 (
  input  wire clk,
  input  wire arst_n,
  input  wire d,
  output reg  q
);

  reg meta_r;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // rtcc_sync2

`default_nettype wire

// ===== rtcc_top.v
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"

// Functional notes
// - adjust clears seconds 0-29; 30-59 clears seconds and carries into minutes
// - adjust acts as a one system clock pulse, then clears itself
// - reset register write-only; bit7 disables 1 Hz, bit6 disables 16 Hz
// - writing alarm reset bit 4 clears the alarm field flags until the fields are written again
// - divider reset bit 5 clears divider; no seconds carry for 0.5 s
// - 1 Hz derived from 32.768 kHz through a 15-stage binary divider
// - time counters advance on rising edge of internal 1 Hz
// - with counting disabled, carries blocked and one seconds carry held
// - only one held carry; longer disable loses seconds
// - alarm pin shows selected source; interrupt pulse on its falling edge
// - alarm enabled and both disables set: pin low on alarm match
// - alarm disabled: 0/1 gives 1 Hz, 1/0 gives 16 Hz, else 0
// - alarm reset makes all alarm fields don't-care, which always match
// - written alarm field stays set until the next alarm reset
// - interrupt on alarm match needs interrupt enable and alarm enable
// - page select 1 maps alarm page, 0 maps clock page
// - system reset leaves time and alarm values uninitialised
// - page control: irq enable b7, adjust b4, count b3, alarm b2, page b0
// - time fields are bcd counters with calendar limits and 12/24 hour
module rtcc_top #(
  parameter DIV_STAGES = `RTCC_DIV_STAGES
) (
  input  wire                      CORE_CLK,
  input  wire                      ARST_N,
  input  wire [`RTCC_ADDR_W-1:0]   ADDR,
  input  wire [7:0]                WDATA,
  input  wire                      WR,
  input  wire                      RD,
  output reg  [7:0]                RDATA,
  input  wire                      TICK_32K,
  output reg                       ALARM,
  output reg                       RTC_INTERRUPT
);

  // control state
  reg                   irq_en_r;
  reg                   count_en_r;
  reg                   alarm_en_r;
  reg                   page_r;
  reg                   slow_dis_r;
  reg                   fast_dis_r;
  reg                   adjust_r;
  reg                   div_rst_r;
  reg                   alm_rst_r;
  reg                   hold_r;
  reg                   slow_prev_r;
  reg [DIV_STAGES-1:0]  div_r;
  reg [3:0]             alm_set_r;
  // time and alarm values: left uninitialised by reset
  reg [7:0]             sec_r;
  reg [7:0]             min_r;
  reg [7:0]             hour_r;
  reg [7:0]             wday_r;
  reg [7:0]             date_r;
  reg [7:0]             month_r;
  reg [7:0]             year_r;
  reg                   mode24_r;
  reg [1:0]             leap_r;
  reg [7:0]             amin_r;
  reg [7:0]             ahour_r;
  reg [7:0]             awday_r;
  reg [7:0]             adate_r;

  reg [7:0]             sec_nxt;
  reg [7:0]             min_nxt;
  reg [7:0]             hour_nxt;
  reg [7:0]             wday_nxt;
  reg [7:0]             date_nxt;
  reg [7:0]             month_nxt;
  reg [7:0]             year_nxt;
  reg [1:0]             leap_nxt;
  reg [7:0]             hinc;
  reg                   min_cy;
  reg                   hr_cy;
  reg                   day_cy;
  reg                   mon_cy;
  reg                   yr_cy;
  reg                   src_c;
  reg [7:0]             rd_mux;

  wire                  slow_s;
  wire                  slow_edge;
  wire                  sec_tick;
  wire                  sec_go;
  wire                  alm_match;
  wire                  wr_p0;
  wire                  wr_p1;

  // bcd increment of a two-digit value
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // last date of the month; february follows the leap counter
  function [7:0] last_date;
    input [7:0] mon;
    input [1:0] leap;
    begin
      case (mon)
        8'h02: begin
          last_date = (leap == 2'b00) ? 8'h29 : 8'h28;
        end
        8'h04, 8'h06, 8'h09, 8'h11: begin
          last_date = 8'h30;
        end
        default: begin
          last_date = 8'h31;
        end
      endcase
    end
  endfunction

  // the slow input is sampled by the system clock, so bring it in cleanly
  rtcc_sync2 u_slow_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .d      (TICK_32K),
    .q      (slow_s)
  );

  assign slow_edge = slow_s & ~slow_prev_r;
  // 1 hz rises when the top stage goes high
  assign sec_tick  = slow_edge & ~div_rst_r & ~div_r[DIV_STAGES-1] &
                     (&div_r[DIV_STAGES-2:0]);
  assign sec_go    = count_en_r & (sec_tick | hold_r);
  assign wr_p0     = WR & ~page_r;
  assign wr_p1     = WR & page_r;

  // divider and held carry; divider reset restarts a full half second
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slow_prev_r <= 1'b0;
      div_r       <= {DIV_STAGES{1'b0}};
      hold_r      <= 1'b0;
    end else begin
      slow_prev_r <= slow_s;
      if (div_rst_r) begin
        div_r <= {DIV_STAGES{1'b0}};
      end else if (slow_edge) begin
        div_r <= div_r + {{(DIV_STAGES-1){1'b0}}, 1'b1};
      end
      // a single flag: a second carry while disabled is simply lost
      if (!count_en_r && sec_tick) begin
        hold_r <= 1'b1;
      end else if (count_en_r) begin
        hold_r <= 1'b0;
      end
    end
  end

  // carry chain through the calendar
  always @* begin
    sec_nxt   = sec_r;
    min_nxt   = min_r;
    hour_nxt  = hour_r;
    wday_nxt  = wday_r;
    date_nxt  = date_r;
    month_nxt = month_r;
    year_nxt  = year_r;
    leap_nxt  = leap_r;
    hinc      = bcd_inc({3'b000, hour_r[4:0]});
    min_cy    = 1'b0;
    hr_cy     = 1'b0;
    day_cy    = 1'b0;
    mon_cy    = 1'b0;
    yr_cy     = 1'b0;
    // adjust takes priority over a tick in the same cycle
    if (adjust_r) begin
      sec_nxt = 8'h00;
      min_cy  = (sec_r >= 8'h30);
    end else if (sec_go) begin
      if (sec_r == 8'h59) begin
        sec_nxt = 8'h00;
        min_cy  = 1'b1;
      end else begin
        sec_nxt = bcd_inc(sec_r);
      end
    end
    if (min_cy) begin
      if (min_r == 8'h59) begin
        min_nxt = 8'h00;
        hr_cy   = 1'b1;
      end else begin
        min_nxt = bcd_inc(min_r);
      end
    end
    if (hr_cy) begin
      if (mode24_r) begin
        if (hour_r == 8'h23) begin
          hour_nxt = 8'h00;
          day_cy   = 1'b1;
        end else begin
          hour_nxt = bcd_inc(hour_r);
        end
      end else if (hour_r[4:0] == 5'h11) begin
        // 11 am goes to 0 pm; 11 pm goes to 0 am of the next day
        hour_nxt = {2'b00, ~hour_r[5], 5'h00};
        day_cy   = hour_r[5];
      end else begin
        hour_nxt = {2'b00, hour_r[5], hinc[4:0]};
      end
    end
    if (day_cy) begin
      wday_nxt = (wday_r == 8'h06) ? 8'h00 : bcd_inc(wday_r);
      if (date_r == last_date(month_r, leap_r)) begin
        date_nxt = 8'h01;
        mon_cy   = 1'b1;
      end else begin
        date_nxt = bcd_inc(date_r);
      end
    end
    if (mon_cy) begin
      if (month_r == 8'h12) begin
        month_nxt = 8'h01;
        yr_cy     = 1'b1;
      end else begin
        month_nxt = bcd_inc(month_r);
      end
    end
    if (yr_cy) begin
      year_nxt = (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
      leap_nxt = leap_r + 2'b01;
    end
  end

  // time and alarm values carry no reset; a software write beats a carry
  always @(posedge CORE_CLK) begin
    sec_r    <= (wr_p0 && ADDR == `RTCC_OFS_SEC)   ? (WDATA & `RTCC_MASK_SEC)   : sec_nxt;
    min_r    <= (wr_p0 && ADDR == `RTCC_OFS_MIN)   ? (WDATA & `RTCC_MASK_MIN)   : min_nxt;
    hour_r   <= (wr_p0 && ADDR == `RTCC_OFS_HOUR)  ? (WDATA & `RTCC_MASK_HOUR)  : hour_nxt;
    wday_r   <= (wr_p0 && ADDR == `RTCC_OFS_WDAY)  ? (WDATA & `RTCC_MASK_WDAY)  : wday_nxt;
    date_r   <= (wr_p0 && ADDR == `RTCC_OFS_DATE)  ? (WDATA & `RTCC_MASK_DATE)  : date_nxt;
    month_r  <= (wr_p0 && ADDR == `RTCC_OFS_MONTH) ? (WDATA & `RTCC_MASK_MONTH) : month_nxt;
    year_r   <= (wr_p0 && ADDR == `RTCC_OFS_YEAR)  ? WDATA : year_nxt;
    leap_r   <= (wr_p1 && ADDR == `RTCC_OFS_YEAR)  ? WDATA[1:0] : leap_nxt;
    if (wr_p1 && ADDR == `RTCC_OFS_MONTH) begin
      mode24_r <= WDATA[0];
    end
    if (wr_p1 && ADDR == `RTCC_OFS_MIN) begin
      amin_r <= WDATA & `RTCC_MASK_MIN;
    end
    if (wr_p1 && ADDR == `RTCC_OFS_HOUR) begin
      ahour_r <= WDATA & `RTCC_MASK_HOUR;
    end
    if (wr_p1 && ADDR == `RTCC_OFS_WDAY) begin
      awday_r <= WDATA & `RTCC_MASK_WDAY;
    end
    if (wr_p1 && ADDR == `RTCC_OFS_DATE) begin
      adate_r <= WDATA & `RTCC_MASK_DATE;
    end
  end

  // a field that was never written is don't-care and always matches
  assign alm_match = (~alm_set_r[0] | (amin_r  == min_r))  &
                     (~alm_set_r[1] | (ahour_r == hour_r)) &
                     (~alm_set_r[2] | (awday_r == wday_r)) &
                     (~alm_set_r[3] | (adate_r == date_r));

  // alarm pin source selection
  always @* begin
    if (alarm_en_r) begin
      src_c = (slow_dis_r & fast_dis_r) ? ~alm_match : 1'b0;
    end else if (!slow_dis_r && fast_dis_r) begin
      src_c = div_r[DIV_STAGES-1];
    end else if (slow_dis_r && !fast_dis_r) begin
      src_c = div_r[DIV_STAGES-1-`RTCC_FAST_TAP_BACK];
    end else begin
      src_c = 1'b0;
    end
  end

  // control registers, command pulses, alarm field flags and outputs
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_en_r      <= `RTCC_RST_IRQ_EN;
      count_en_r    <= `RTCC_RST_COUNT_EN;
      alarm_en_r    <= `RTCC_RST_ALARM_EN;
      page_r        <= `RTCC_RST_PAGE;
      slow_dis_r    <= `RTCC_RST_SLOW_DIS;
      fast_dis_r    <= `RTCC_RST_FAST_DIS;
      adjust_r      <= 1'b0;
      div_rst_r     <= 1'b0;
      alm_rst_r     <= 1'b0;
      alm_set_r     <= 4'h0;
      ALARM         <= 1'b1;
      RTC_INTERRUPT <= 1'b0;
    end else begin
      // pulses last exactly one cycle and need no clearing write
      adjust_r  <= 1'b0;
      div_rst_r <= 1'b0;
      alm_rst_r <= 1'b0;
      if (WR && ADDR == `RTCC_OFS_PAGE_CTRL) begin
        irq_en_r   <= WDATA[`RTCC_PC_IRQ_EN];
        count_en_r <= WDATA[`RTCC_PC_COUNT_EN];
        alarm_en_r <= WDATA[`RTCC_PC_ALARM_EN];
        page_r     <= WDATA[`RTCC_PC_PAGE];
        // adjust only applies to the clock page
        adjust_r   <= WDATA[`RTCC_PC_ADJUST] & ~WDATA[`RTCC_PC_PAGE];
      end
      // write-only; low nibble ignored
      if (WR && ADDR == `RTCC_OFS_RESET_CTRL) begin
        slow_dis_r <= WDATA[`RTCC_RC_SLOW_DIS];
        fast_dis_r <= WDATA[`RTCC_RC_FAST_DIS];
        div_rst_r  <= WDATA[`RTCC_RC_DIV_RST];
        alm_rst_r  <= WDATA[`RTCC_RC_ALM_RST];
      end
      // a field write in the reset pulse cycle still marks the field
      alm_set_r <= (alm_rst_r ? 4'h0 : alm_set_r) |
                   {wr_p1 && ADDR == `RTCC_OFS_DATE, wr_p1 && ADDR == `RTCC_OFS_WDAY,
                    wr_p1 && ADDR == `RTCC_OFS_HOUR, wr_p1 && ADDR == `RTCC_OFS_MIN};
      ALARM         <= src_c;
      // one-shot on the falling edge of the pin source
      RTC_INTERRUPT <= irq_en_r & ALARM & ~src_c;
    end
  end

  // read mux; the control page bit selects alarm or clock view
  always @* begin
    rd_mux = 8'h00;
    case (ADDR)
      `RTCC_OFS_SEC: begin
        rd_mux = page_r ? 8'h00 : sec_r;
      end
      `RTCC_OFS_MIN: begin
        rd_mux = page_r ? amin_r : min_r;
      end
      `RTCC_OFS_HOUR: begin
        rd_mux = page_r ? ahour_r : hour_r;
      end
      `RTCC_OFS_WDAY: begin
        rd_mux = page_r ? awday_r : wday_r;
      end
      `RTCC_OFS_DATE: begin
        rd_mux = page_r ? adate_r : date_r;
      end
      `RTCC_OFS_MONTH: begin
        rd_mux = page_r ? {7'h00, mode24_r} : month_r;
      end
      `RTCC_OFS_YEAR: begin
        rd_mux = page_r ? {6'h00, leap_r} : year_r;
      end
      `RTCC_OFS_PAGE_CTRL: begin
        rd_mux = {irq_en_r, 3'b000, count_en_r, alarm_en_r, 1'b0, page_r};
      end
      default: begin
        rd_mux = 8'h00; // reset control is write-only and reads zero
      end
    endcase
  end

  // read data only in the cycle after the strobe
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

endmodule // rtcc_top

`default_nettype wire

// ===== rtcc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"

module rtcc_top_asserts #(
  parameter DIV_STAGES = `RTCC_DIV_STAGES
) (
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic        TICK_32K,
  input wire logic        ALARM,
  input wire logic        RTC_INTERRUPT
);
  // control bits rebuilt from write traffic only
  logic [7:0] pc_r;
  logic [1:0] dis_r;
  wire        pc_wr = WR && ADDR == `RTCC_OFS_PAGE_CTRL;
  wire        rc_wr = WR && ADDR == `RTCC_OFS_RESET_CTRL;
  wire        mapped = (ADDR >= `RTCC_OFS_SEC && ADDR <= `RTCC_OFS_PAGE_CTRL) || ADDR == `RTCC_OFS_RESET_CTRL;
  wire        mode_zero = !pc_r[2] && dis_r[1] == dis_r[0];

  // adjust bit left out of the mirror, it never reads back
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_r  <= 8'h00;
      dis_r <= 2'b11;
    end else begin
      if (pc_wr) pc_r <= WDATA & 8'h8d;
      if (rc_wr) dis_r <= WDATA[7:6];
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // antecedent sequences; only s_zero_held spans more than one cycle
  sequence s_rd_rc;
    RD && ADDR == `RTCC_OFS_RESET_CTRL;
  endsequence
  sequence s_zero_held;
    mode_zero [*3];
  endsequence
  sequence s_alm_rst;
    rc_wr && WDATA[4] && WDATA[7:6] == 2'b11 && pc_r[2];
  endsequence

  a_rd_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data not zero when idle");
  a_rc_read_zero: assert property (s_rd_rc |=> RDATA == 8'h00) else $error("reset control readable");
  a_unmapped_zero: assert property (RD && !mapped |=> RDATA == 8'h00) else $error("unmapped read not zero");
  a_pc_read_bits: assert property (RD && ADDR == `RTCC_OFS_PAGE_CTRL |=> RDATA == pc_r) else $error("page ctrl read");
  a_irq_on_fall: assert property (RTC_INTERRUPT |-> $fell(ALARM)) else $error("interrupt without alarm fall");
  a_irq_one_shot: assert property (RTC_INTERRUPT |=> !RTC_INTERRUPT) else $error("interrupt longer than one cycle");
  a_irq_gated: assert property (RTC_INTERRUPT |-> pc_r[7] || $past(pc_r[7])) else $error("interrupt while disabled");
  a_zero_mode_low: assert property (s_zero_held |-> ALARM == 1'b0) else $error("alarm pin not low");
  a_alm_rst_match: assert property (s_alm_rst |-> ##[1:4] !ALARM) else $error("alarm reset gave no match");
endmodule // rtcc_top_asserts

bind rtcc_top rtcc_top_asserts #(.DIV_STAGES(DIV_STAGES)) i_rtcc_top_asserts (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TICK_32K(TICK_32K), .ALARM(ALARM), .RTC_INTERRUPT(RTC_INTERRUPT));

`default_nettype wire

// ===== rtcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"

module rtcc_top_tb;
  localparam int          NDIV = 6;
  localparam int          HALF = (2 ** (NDIV - 1)) * 6;  // half second: slow edge every 6 cycles
  localparam int          SETUP = 1550;                  // 31 us at 50 mhz
  localparam logic [15:0] SEC = `RTCC_OFS_SEC;
  localparam logic [15:0] MIN = `RTCC_OFS_MIN;
  localparam logic [15:0] HOUR = `RTCC_OFS_HOUR;
  localparam logic [15:0] WDAY = `RTCC_OFS_WDAY;
  localparam logic [15:0] DATE = `RTCC_OFS_DATE;
  localparam logic [15:0] MONTH = `RTCC_OFS_MONTH;
  localparam logic [15:0] YEAR = `RTCC_OFS_YEAR;
  localparam logic [15:0] PC = `RTCC_OFS_PAGE_CTRL;
  localparam logic [15:0] RC = `RTCC_OFS_RESET_CTRL;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tick = 1'b0;
  logic        rd_q = 1'b0;
  wire  [7:0]  rdata;
  wire         alarm;
  wire         irq;
  logic [7:0]  exp_q[$];
  string       name_q[$];
  logic [7:0]  s;
  logic [7:0]  mode [4] = '{8'h60, 8'ha0, 8'h20, 8'he0};
  int          lo [4] = '{1, 27, 0, 0};
  int          hi [4] = '{2, 29, 1, 0};
  int          err_total = 0;
  int          check_count = 0;
  int          irq_n = 0;
  int          n0;
  int          seed;

  rtcc_top #(.DIV_STAGES(NDIV)) i_rtcc_top (
    .CORE_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TICK_32K(tick), .ALARM(alarm), .RTC_INTERRUPT(irq));

  // core clock and a free-running slow oscillator, period six core cycles
  always #10 clk = ~clk;
  always begin
    repeat (3) @(posedge clk);
    tick <= ~tick;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
    check_count++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, v);
    end
  endtask

  // one-cycle strobes; a gap cycle follows so no strobe is set twice at one edge
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic test_done;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe, so compare then
  always @(posedge clk) begin
    rd_q <= rd;
    if (irq === 1'b1) irq_n++;
    if (rd_q) chk(name_q.pop_front(), exp_q.pop_front(), rdata);
  end

  initial begin
    seed = $urandom(32'h62ab0cfb);
    cyc(6);
    arst_n <= 1'b1;
    rd_reg(RC, 8'h00, "reset_ctrl");
    rd_reg(PC, 8'h00, "page_ctrl");
    rd_reg(16'h0330, 8'h00, "unmapped");
    // adjust around the 29/30 boundary, then random seconds
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 8'h29 : (i == 1) ? 8'h30 : {1'b0, 3'($urandom_range(5)), 4'($urandom_range(9))};
      wr_reg(RC, 8'he0);
      wr_reg(MIN, 8'h10);
      wr_reg(SEC, s);
      wr_reg(PC, 8'h18);
      rd_reg(SEC, 8'h00, "sec");
      rd_reg(MIN, (s >= 8'h30) ? 8'h11 : 8'h10, "min");
      rd_reg(PC, 8'h08, "page_ctrl");
      wr_reg(SEC, 8'h45);
      rd_reg(SEC, 8'h45, "sec");
    end
    // adjust ripples through the calendar: 24 h at year end, then 12 h at 11 pm on the last of february
    wr_reg(RC, 8'he0);
    for (int m = 0; m < 2; m++) begin
      wr_reg(PC, 8'h09);
      wr_reg(MONTH, m ? 8'h00 : 8'h01);
      wr_reg(YEAR, m ? 8'h01 : 8'h00);
      wr_reg(PC, 8'h08);
      wr_reg(HOUR, m ? 8'h31 : 8'h23);
      wr_reg(WDAY, 8'h06);
      wr_reg(DATE, m ? 8'h28 : 8'h31);
      wr_reg(MONTH, m ? 8'h02 : 8'h12);
      wr_reg(YEAR, 8'h99);
      wr_reg(MIN, 8'h59);
      wr_reg(SEC, 8'h45);
      wr_reg(PC, 8'h18);
      rd_reg(MIN, 8'h00, "min");
      rd_reg(HOUR, 8'h00, "hour");
      rd_reg(WDAY, 8'h00, "wday");
      rd_reg(DATE, 8'h01, "date");
      rd_reg(MONTH, m ? 8'h03 : 8'h01, "month");
      rd_reg(YEAR, m ? 8'h99 : 8'h00, "year");
      wr_reg(PC, 8'h09);
      rd_reg(YEAR, 8'h01, "leap");
    end
    // back to the clock page, later second writes would be lost otherwise
    wr_reg(PC, 8'h08);
    // divider reset keeps the first carry half a second away
    wr_reg(RC, 8'he0);
    wr_reg(SEC, 8'h00);
    cyc(HALF - 40);
    rd_reg(SEC, 8'h00, "sec");
    cyc(60);
    rd_reg(SEC, 8'h01, "sec");
    // two carries while stopped, only one survives
    wr_reg(RC, 8'he0);
    wr_reg(PC, 8'h00);
    wr_reg(SEC, 8'h00);
    cyc(3 * HALF + HALF / 2);
    rd_reg(SEC, 8'h00, "sec");
    wr_reg(PC, 8'h08);
    rd_reg(SEC, 8'h01, "sec");
    rd_reg(SEC, 8'h01, "sec");
    // alarm field written while alarm is off, then enabled after setup time
    wr_reg(MIN, 8'h10);
    for (int j = 0; j < 2; j++) begin
      wr_reg(PC, 8'h09);
      wr_reg(MIN, 8'h59);
      cyc(SETUP);
      wr_reg(PC, (j == 0) ? 8'h8d : 8'h0d);
      cyc(6);
      chk("alarm", 8'h01, {7'h00, alarm});
      rd_reg(MIN, 8'h59, "alarm_min");
      n0 = irq_n;
      wr_reg(RC, 8'hd0);
      cyc(6);
      chk("alarm", 8'h00, {7'h00, alarm});
      chk("irq", (j == 0) ? 8'h01 : 8'h00, 8'(irq_n - n0));
      // time read back on the clock page soon after the alarm match
      wr_reg(PC, 8'h0c);
      rd_reg(MIN, 8'h10, "min");
    end
    // remaining alarm fields: a wrong hour blocks the match, matching values give it
    for (int q = 0; q < 2; q++) begin
      wr_reg(PC, 8'h09);
      wr_reg(HOUR, q ? 8'h00 : 8'h12);
      wr_reg(WDAY, 8'h00);
      wr_reg(DATE, 8'h01);
      cyc(SETUP);
      wr_reg(PC, 8'h0d);
      cyc(6);
      chk("alarm", q ? 8'h00 : 8'h01, {7'h00, alarm});
    end
    // every source selection with the alarm off; a mode switch may add one fall
    wr_reg(PC, 8'h80);
    for (int k = 0; k < 4; k++) begin
      n0 = irq_n;
      wr_reg(RC, mode[k]);
      cyc(3 * HALF + HALF / 2);
      chk("tick_falls", 8'h01, {7'h00, irq_n - n0 >= lo[k] && irq_n - n0 <= hi[k]});
    end
    test_done();
  end

  // hang guard, well beyond the roughly ten thousand cycles the sequence needs
  initial begin
    cyc(20000);
    err_total++;
    test_done();
  end
endmodule // rtcc_top_tb

`default_nettype wire
